// File: common/dscs_pkg.sv
// package of the disk sector command sequencer: offsets, fields, types
// assumes one 100 MHz clock domain and a byte-wide register port
package dscs_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_OPCMD = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_ERROR = 8'h03;
  localparam logic [7:0] REG_SECT_CNT = 8'h04;
  localparam logic [7:0] REG_HDR_BYTE_CNT = 8'h05;
  localparam logic [7:0] REG_SUBST = 8'h06;
  localparam logic [7:0] REG_PAT_BASE = 8'h08;
  localparam logic [7:0] REG_SECT_OP_CNT = 8'h13;
  // ---------------------------------------------------------------
  // field positions and sizes
  // ---------------------------------------------------------------
  localparam int HDR_BYTES = 4;
  localparam int CMD_SOFT = 0;
  localparam int CMD_MULTI = 1;
  localparam int CMD_START = 2;
  localparam int CMD_FMT = 3;
  localparam int OP_RESET = 0;
  localparam int OP_REEN = 1;
  localparam int OP_ILOCK = 2;
  localparam int OP_HINT = 3;
  localparam int ERR_LATE = 0;
  localparam int ERR_HDR = 1;
  localparam int ERR_DATA = 2;
  localparam int ERR_ILL = 3;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h00;
  localparam logic [7:0] SYNCH1_BYTE = 8'hA1;
  localparam logic [7:0] SYNCH2_BYTE = 8'hFE;
  localparam int PREAMBLE_LEN = 4;
  // ---------------------------------------------------------------
  // header and data op codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HOP_IGNORE = 2'b00, HOP_COMPARE = 2'b01,
    HOP_WRITE = 2'b10, HOP_READ = 2'b11
  } dscs_hop_t;
  typedef enum logic [1:0] {
    DOP_NONE = 2'b00, DOP_CHECK = 2'b01,
    DOP_WRITE = 2'b10, DOP_READ = 2'b11
  } dscs_dop_t;
  // sequencer states, gray from ST_IDLE through ST_WAIT, ST_HDR and ST_DATA to ST_NEXT
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_WAIT = 4'b0001, ST_HDR = 4'b0011,
    ST_DATA = 4'b0010, ST_NEXT = 4'b0110, ST_ERR = 4'b0111,
    ST_HALT = 4'b0101
  } dscs_state_t;
  // register port bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dscs_bus_t;
  // drive side byte stream (serializer assumed outside)
  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic crc_ok;
    logic crc_last;
    logic synch_ok;
  } dscs_rx_t;
endpackage

// File: design/dscs_top.sv
// sequencer of disk header and data operations on one track
// assumes drive bytes arrive deserialised, one per valid pulse, with
// crc results attached; sector and index pulses are raw pins
//
// The implementer's own choice: strobed register access.
module dscs_top #(
  parameter int DATA_LEN = 256
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire dscs_pkg::dscs_bus_t bus,
  output logic [7:0] rdata,
  input wire logic sector_pin,
  input wire logic index_pin,
  input wire dscs_pkg::dscs_rx_t rx,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_crc_append,
  output logic fifo_push,
  output logic [7:0] fifo_wdata,
  output logic fifo_pop,
  input wire logic [7:0] fifo_rdata,
  output logic next_cmd_ready,
  output logic busy
);
  import dscs_pkg::*;

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic rs1_q, rs2_q, rst_l;
  logic sec1_q, sec2_q, sec3_q, idx1_q, idx2_q, idx3_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  assign rst_l = rs2_q;

  // pins pass two flops; the third only serves edge detection
  always_ff @(posedge core_clk or negedge rst_l) begin
    if (!rst_l) begin
      {sec1_q, sec2_q, sec3_q} <= 3'b000;
      {idx1_q, idx2_q, idx3_q} <= 3'b000;
    end else begin
      {sec1_q, sec2_q, sec3_q} <= {sector_pin, sec1_q, sec2_q};
      {idx1_q, idx2_q, idx3_q} <= {index_pin, idx1_q, idx2_q};
    end
  end
  wire sec_edge = sec2_q & ~sec3_q;
  wire idx_edge = idx2_q & ~idx3_q;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] cmd_q, opcmd_q, err_q, sect_cnt_q, hbc_q, subst_q;
  logic [7:0] sop_cnt_q, rdata_q;
  logic [7:0] pat_q [HDR_BYTES];
  logic hbc_written_q;
  dscs_state_t st_q, st_d;
  logic [8:0] cnt_q;
  logic [1:0] ph_q;
  logic match_q;

  wire wr_cmd = bus.wr && bus.addr == REG_CMD;
  wire wr_op = bus.wr && bus.addr == REG_OPCMD;
  wire wr_sc = bus.wr && bus.addr == REG_SECT_CNT;
  wire wr_hbc = bus.wr && bus.addr == REG_HDR_BYTE_CNT;
  wire wr_sub = bus.wr && bus.addr == REG_SUBST;
  wire wr_sop = bus.wr && bus.addr == REG_SECT_OP_CNT;
  wire pat_sel = bus.addr >= REG_PAT_BASE &&
    bus.addr < REG_PAT_BASE + 8'(HDR_BYTES);
  wire [1:0] pat_idx = 2'(bus.addr - REG_PAT_BASE);

  // decoded command bits
  wire [1:0] c_dop = cmd_q[7:6];
  wire [1:0] c_hop = cmd_q[5:4];
  wire ilock = opcmd_q[OP_ILOCK] & opcmd_q[OP_HINT];
  // illegal combinations refused, none illegal only with header read
  wire illegal = (c_dop == DOP_NONE && c_hop == HOP_READ) ||
    (c_dop == DOP_READ && c_hop == HOP_WRITE) ||
    (c_dop == DOP_WRITE && c_hop == HOP_READ);
  wire is_nop = c_dop == DOP_NONE && c_hop == HOP_IGNORE;

  // expected header byte: pattern or sector counter
  function automatic logic [7:0] hdr_exp(input logic [1:0] i,
      input logic [7:0] sub, input logic [7:0] pat, input logic [7:0] sc);
    hdr_exp = sub[i] ? sc : pat;
  endfunction

  wire [1:0] hi = cnt_q[1:0];
  wire [7:0] exp_b = hdr_exp(hi, subst_q, pat_q[hi], sect_cnt_q);
  wire rx_v = rx.valid;
  wire hdr_data_end = cnt_q == 9'(HDR_BYTES);
  wire data_end = cnt_q == 9'(DATA_LEN);
  wire halted = st_q == ST_ERR || st_q == ST_HALT;

  // ---------------------------------------------------------------
  // register writes; sector completion wins over counter writes
  // ---------------------------------------------------------------
  logic set_late, set_hdr, set_data, set_ill, sect_done;
  always_ff @(posedge core_clk or negedge rst_l) begin
    if (!rst_l) begin
      cmd_q <= RST_ZERO;
      opcmd_q <= RST_ZERO;
      sect_cnt_q <= RST_ZERO;
      hbc_q <= RST_ZERO;
      subst_q <= RST_ZERO;
      sop_cnt_q <= RST_ZERO;
      hbc_written_q <= 1'b0;
      for (int i = 0; i < HDR_BYTES; i++) pat_q[i] <= RST_ZERO;
    end else begin
      // a finished command does not block the next one
      if (wr_cmd && st_q != ST_ERR) cmd_q <= bus.wdata;
      if (wr_op) opcmd_q <= bus.wdata;
      if (wr_sub) subst_q <= bus.wdata;
      if (bus.wr && pat_sel) pat_q[pat_idx] <= bus.wdata;
      if (wr_hbc) hbc_q <= bus.wdata;
      // count up sector and down operations after each sector
      if (sect_done) begin
        sect_cnt_q <= sect_cnt_q + 8'h01;
        sop_cnt_q <= sop_cnt_q - 8'h01;
      end else begin
        if (wr_sc) sect_cnt_q <= bus.wdata;
        if (wr_sop) sop_cnt_q <= bus.wdata;
      end
      // update handshake armed by header end, met by byte counter write
      if (wr_hbc) hbc_written_q <= 1'b1;
      else if (st_q == ST_HDR && st_d == ST_DATA) hbc_written_q <= 1'b0;
    end
  end

  // error flags sticky until the reset bit
  always_ff @(posedge core_clk or negedge rst_l) begin
    if (!rst_l) err_q <= RST_ZERO;
    else if (set_late | set_hdr | set_data | set_ill)
      err_q <= err_q | {4'h0, set_ill, set_data, set_hdr, set_late};
    else if (opcmd_q[OP_RESET]) err_q <= RST_ZERO;
  end

  // ---------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    set_late = 1'b0;
    set_hdr = 1'b0;
    set_data = 1'b0;
    set_ill = 1'b0;
    sect_done = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        // loading the command starts it
        if (wr_cmd) st_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (illegal) begin
          set_ill = 1'b1;
          st_d = ST_ERR;
        end else if (is_nop) st_d = ST_IDLE;
        else if (cmd_q[CMD_START]) begin
          // next sector, or at once when soft sectored
          if (cmd_q[CMD_SOFT] || sec_edge) st_d = ST_HDR;
        end else if (idx_edge) st_d = ST_HDR;
      end
      ST_HDR: begin
        if (ph_q == 2'd3 && hdr_data_end && (rx_v || c_hop == HOP_WRITE)) begin
          // header result: good crc and full match
          if (c_hop != HOP_WRITE && !rx.crc_ok) set_hdr = 1'b1;
          else if (c_hop == HOP_COMPARE && !match_q) st_d = ST_WAIT;
          else if (c_dop == DOP_NONE) begin
            sect_done = 1'b1;
            st_d = ST_NEXT;
          end else st_d = ST_DATA;
        end
        if (set_hdr) st_d = ST_ERR;
      end
      ST_DATA: begin
        if (ph_q == 2'd3 && data_end && (rx_v || c_dop == DOP_WRITE)) begin
          // data crc verdict at the end
          if (c_dop != DOP_WRITE && !rx.crc_ok) begin
            set_data = 1'b1;
            st_d = ST_ERR;
          end else begin
            sect_done = 1'b1;
            st_d = ST_NEXT;
          end
        end
      end
      ST_NEXT: begin
        // repeat while count remains, else terminate
        if (!cmd_q[CMD_MULTI] || sop_cnt_q == 8'h00) st_d = ST_HALT;
        else if (ilock && !hbc_written_q && sec_edge) begin
          set_late = 1'b1;
          st_d = ST_ERR;
        end else if (!ilock || hbc_written_q) begin
          if (cmd_q[CMD_SOFT] || sec_edge) st_d = ST_HDR;
        end
      end
      ST_HALT: begin
        // a new command after a finished one
        if (wr_cmd) st_d = ST_WAIT;
      end
      ST_ERR: begin
        // leave only via reset bit then re-enable bit
        if (!opcmd_q[OP_RESET] && opcmd_q[OP_REEN] && err_q == RST_ZERO)
          st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // field walker: phase 0 preamble, 1 synch1, 2 synch2, 3 body
  // ---------------------------------------------------------------
  wire in_field = st_q == ST_HDR || st_q == ST_DATA;
  wire wr_field = (st_q == ST_HDR && c_hop == HOP_WRITE) ||
    (st_q == ST_DATA && c_dop == DOP_WRITE);
  wire step = wr_field || rx_v;
  wire ph_end = ph_q == 2'd0 ? cnt_q == 9'(PREAMBLE_LEN - 1) : ph_q != 2'd3;
  wire synch_bad = !wr_field && rx_v && ph_q == 2'd2 && !rx.synch_ok;

  always_ff @(posedge core_clk or negedge rst_l) begin
    if (!rst_l) begin
      st_q <= ST_IDLE;
      ph_q <= 2'd0;
      cnt_q <= 9'd0;
      match_q <= 1'b1;
    end else begin
      st_q <= synch_bad ? ST_WAIT : st_d;
      if (st_d != st_q || !in_field || synch_bad) begin
        ph_q <= 2'd0;
        cnt_q <= 9'd0;
        match_q <= 1'b1;
      end else if (step) begin
        if (ph_q != 2'd3 && ph_end) begin
          ph_q <= ph_q + 2'd1;
          cnt_q <= 9'd0;
        end else cnt_q <= cnt_q + 9'd1;
        // compare each header byte
        if (ph_q == 2'd3 && st_q == ST_HDR && !hdr_data_end &&
            c_hop == HOP_COMPARE && rx.data != exp_b)
          match_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // output stream, fifo strobes, status
  // ---------------------------------------------------------------
  logic [7:0] tx_d;
  always_comb begin
    unique case (ph_q)
      2'd0: tx_d = PREAMBLE_BYTE;
      2'd1: tx_d = SYNCH1_BYTE;
      2'd2: tx_d = SYNCH2_BYTE;
      default: tx_d = st_q == ST_HDR ? exp_b : fifo_rdata;
    endcase
  end
  wire body = in_field && ph_q == 2'd3;
  wire body_byte = body && !(st_q == ST_HDR ? hdr_data_end : data_end);
  // header bytes read go to the fifo, data only on read
  wire push_d = !wr_field && rx_v && body_byte &&
    ((st_q == ST_HDR && c_hop == HOP_READ) ||
     (st_q == ST_DATA && c_dop == DOP_READ));
  wire pop_d = wr_field && st_q == ST_DATA && body_byte;
  // crc appended after body
  wire crc_d = wr_field && body && !body_byte;
  wire ready_d = st_q == ST_HDR && st_d == ST_DATA && ilock;

  wire [7:0] status_w = {3'h0, ready_d, halted, st_q == ST_ERR, 1'b0, busy};
  logic [7:0] rmux;
  always_comb begin
    rmux = RST_ZERO;
    if (bus.addr == REG_CMD) rmux = cmd_q;
    else if (bus.addr == REG_OPCMD) rmux = opcmd_q;
    else if (bus.addr == REG_STATUS) rmux = status_w;
    else if (bus.addr == REG_ERROR) rmux = err_q;
    else if (bus.addr == REG_SECT_CNT) rmux = sect_cnt_q;
    else if (bus.addr == REG_HDR_BYTE_CNT) rmux = hbc_q;
    else if (bus.addr == REG_SUBST) rmux = subst_q;
    else if (bus.addr == REG_SECT_OP_CNT) rmux = sop_cnt_q;
    else if (pat_sel) rmux = pat_q[pat_idx];
  end

  always_ff @(posedge core_clk or negedge rst_l) begin
    if (!rst_l) begin
      rdata_q <= RST_ZERO;
      tx_data <= RST_ZERO;
      tx_valid <= 1'b0;
      tx_crc_append <= 1'b0;
      fifo_push <= 1'b0;
      fifo_wdata <= RST_ZERO;
      fifo_pop <= 1'b0;
      next_cmd_ready <= 1'b0;
      busy <= 1'b0;
    end else begin
      rdata_q <= bus.rd ? rmux : RST_ZERO;
      tx_data <= tx_d;
      tx_valid <= wr_field && !crc_d;
      tx_crc_append <= crc_d;
      fifo_push <= push_d;
      fifo_wdata <= rx.data;
      fifo_pop <= pop_d;
      next_cmd_ready <= ready_d;
      busy <= st_d != ST_IDLE && st_d != ST_HALT && st_d != ST_ERR;
    end
  end
  assign rdata = rdata_q;
endmodule

// File: sim/dscs_asserts.sv
// checker of the sequencer ports: pulses, idle outputs, start latency
// assumes a bind onto dscs_top, one clock, rst_n async active low
module dscs_asserts
  import dscs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire dscs_pkg::dscs_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic fifo_push,
  input wire logic fifo_pop,
  input wire logic tx_valid,
  input wire logic tx_crc_append,
  input wire logic next_cmd_ready,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // port relations
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // read data only in the cycle after a read strobe
  rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data without a read strobe");
  // bytes move only while a command runs
  push_busy_a: assert property (fifo_push |-> busy)
    else $error("fifo push while idle");
  pop_busy_a: assert property (fifo_pop |-> busy)
    else $error("fifo pop while idle");
  tx_busy_a: assert property (tx_valid |-> busy)
    else $error("drive write while idle");
  crc_pulse_a: assert property (tx_crc_append |=> !tx_crc_append)
    else $error("crc append longer than one cycle");
  ready_pulse_a: assert property (next_cmd_ready |=> !next_cmd_ready)
    else $error("ready flag longer than one cycle");
  // busy rises right after the edge that takes the command write
  busy_start_a: assert property ($rose(busy) |->
    $past(bus.wr && bus.addr == REG_CMD, 1))
    else $error("busy without a command write");
  ready_busy_a: assert property (next_cmd_ready |-> busy)
    else $error("ready flag outside a command");
  // main scenarios reached
  cover property (fifo_push);
  cover property (tx_crc_append);
  cover property (next_cmd_ready);
endmodule

bind dscs_top dscs_asserts dscs_asserts_i (
  .core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
  .fifo_push(fifo_push), .fifo_pop(fifo_pop), .tx_valid(tx_valid),
  .tx_crc_append(tx_crc_append), .next_cmd_ready(next_cmd_ready),
  .busy(busy)
);

// File: sim/dscs_drive_model.sv
// drive side model: sector and index pulses, deserialised field bytes
// assumes the bench calls its tasks; bytes spaced by GAP idle cycles
module dscs_drive_model
  import dscs_pkg::*;
#(
  parameter int GAP = 1
) (
  input wire logic core_clk,
  output logic sector_pin,
  output logic index_pin,
  output dscs_pkg::dscs_rx_t rx
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // byte and pulse tasks
  // ---------------------------------------------------------------
  initial begin
    sector_pin = 1'b0;
    index_pin = 1'b0;
    rx = '0;
  end
  // idle cycles scramble data so a stale byte is never reused
  task automatic put(input logic [7:0] b, input logic s, input logic c);
    @(posedge core_clk);
    rx <= '{data: b, valid: 1'b1, crc_ok: c, crc_last: c, synch_ok: s};
    repeat (GAP) begin
      @(posedge core_clk);
      rx <= '{data: ~b, valid: 1'b0, crc_ok: 1'b0, crc_last: 1'b0,
        synch_ok: 1'b0};
    end
  endtask
  // held several cycles so the two-flop sync sees the rising edge
  task automatic pulse(input logic idx);
    @(posedge core_clk);
    if (idx) index_pin <= 1'b1;
    else sector_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
    index_pin <= 1'b0;
    sector_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  // preamble, two synch bytes, four body bytes, crc verdict byte
  task automatic field(input logic [31:0] body, input logic ok);
    repeat (PREAMBLE_LEN) put(PREAMBLE_BYTE, 1'b0, 1'b0);
    put(SYNCH1_BYTE, 1'b0, 1'b0);
    put(SYNCH2_BYTE, 1'b1, 1'b0);
    for (int i = 3; i >= 0; i--) put(body[i*8 +: 8], 1'b0, 1'b0);
    put(8'h00, 1'b0, ok);
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// File: sim/tb_top.sv
// self-checking bench of the sequencer through its register port
// assumes the drive model feeds fields; fifo read data held fixed
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dscs_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  dscs_bus_t bus = '0;
  logic [7:0] rdata, tx_data, fifo_wdata, v;
  logic sector_pin, index_pin, tx_valid, tx_crc_append;
  logic fifo_push, fifo_pop, next_cmd_ready, busy;
  logic [7:0] fifo_rdata = 8'h5A;
  dscs_rx_t rx;
  logic [63:0] push_sig = '0;
  logic [63:0] tx_sig = '0;
  int push_n = 0, tx_n = 0, crc_n = 0, rdy_n = 0, pop_n = 0;
  int fails = 0, total_checks = 0;
  // ---------------------------------------------------------------
  // clock, design and drive
  // ---------------------------------------------------------------
  always #5 core_clk = ~core_clk;
  dscs_top #(.DATA_LEN(4)) dscs_top_i (
    .core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .sector_pin(sector_pin), .index_pin(index_pin), .rx(rx),
    .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_crc_append(tx_crc_append), .fifo_push(fifo_push),
    .fifo_wdata(fifo_wdata), .fifo_pop(fifo_pop),
    .fifo_rdata(fifo_rdata), .next_cmd_ready(next_cmd_ready),
    .busy(busy)
  );
  dscs_drive_model drv (
    .core_clk(core_clk), .sector_pin(sector_pin),
    .index_pin(index_pin), .rx(rx)
  );
  // collect what the sequencer hands on, byte by byte
  always @(posedge core_clk) begin
    if (fifo_push) begin
      push_sig <= {push_sig[55:0], fifo_wdata};
      push_n <= push_n + 1;
    end
    if (tx_valid) begin
      tx_sig <= {tx_sig[55:0], tx_data};
      tx_n <= tx_n + 1;
    end
    if (tx_crc_append) crc_n <= crc_n + 1;
    if (next_cmd_ready) rdy_n <= rdy_n + 1;
    if (fifo_pop) pop_n <= pop_n + 1;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '0;
  endtask
  // read data is looked at in the one cycle that it stands
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    @(negedge core_clk);
    v = rdata;
    check({56'h0, v}, {56'h0, e});
  endtask
  task automatic wait_idle();
    int n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 5000) begin
      fails++;
      final_report();
    end
  endtask
  task automatic clr();
    push_sig = '0;
    tx_sig = '0;
    push_n = 0;
    tx_n = 0;
    crc_n = 0;
    rdy_n = 0;
    pop_n = 0;
  endtask
  // soft sectored command byte
  function automatic logic [7:0] cmd(input dscs_dop_t d,
    input dscs_hop_t h, input logic st, input logic mu);
    return {d, h, 1'b0, st, mu, 1'b1};
  endfunction
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rchk(REG_SECT_OP_CNT, RST_ZERO);
    wr(REG_SECT_OP_CNT, 8'hFF);
    rchk(REG_SECT_OP_CNT, 8'hFF);
    rchk(8'h07, 8'h00);
    // ignore header, read data, start at once
    clr();
    wr(REG_CMD, cmd(DOP_READ, HOP_IGNORE, 1'b1, 1'b0));
    repeat (2) @(posedge core_clk);
    #1 check(busy, 1'b1);
    drv.field(32'h01020304, 1'b1);
    drv.field(32'hA0B1C2D3, 1'b1);
    wait_idle();
    check(push_sig, 64'hA0B1C2D3);
    check(push_n, 4);
    // read header, check data, wait for index
    clr();
    wr(REG_CMD, cmd(DOP_CHECK, HOP_READ, 1'b0, 1'b0));
    drv.field(32'h11223344, 1'b1);
    check(push_n, 0);
    drv.pulse(1'b1);
    drv.field(32'h55667788, 1'b1);
    drv.field(32'h99AABBCC, 1'b1);
    wait_idle();
    check(push_sig, 64'h55667788);
    check(push_n, 4);
    // compare with substituted sector number over two sectors
    clr();
    wr(REG_SECT_CNT, 8'h05);
    wr(REG_SUBST, 8'h01);
    for (int i = 0; i < HDR_BYTES; i++) wr(REG_PAT_BASE + 8'(i), 8'(16 * i));
    wr(REG_SECT_OP_CNT, 8'h02);
    wr(REG_CMD, cmd(DOP_READ, HOP_COMPARE, 1'b1, 1'b1));
    drv.field(32'h05102031, 1'b1);
    drv.field(32'hDEADBEEF, 1'b1);
    check(push_n, 0);
    drv.field(32'h05102030, 1'b1);
    drv.field(32'h01020304, 1'b1);
    drv.pulse(1'b0);
    drv.field(32'h06102030, 1'b1);
    drv.field(32'h05060708, 1'b1);
    wait_idle();
    check(push_sig, 64'h0102030405060708);
    rchk(REG_SECT_OP_CNT, 8'h00);
    rchk(REG_SECT_CNT, 8'h07);
    // write data after an ignored header
    clr();
    wr(REG_CMD, cmd(DOP_WRITE, HOP_IGNORE, 1'b1, 1'b0));
    drv.field(32'h01020304, 1'b1);
    wait_idle();
    check(tx_sig, 64'h0000A1FE5A5A5A5A);
    check(tx_n, PREAMBLE_LEN + 6);
    check(crc_n, 1);
    check(pop_n, 4);
    // format: written header, then written data, each closed by crc
    clr();
    wr(REG_CMD, cmd(DOP_WRITE, HOP_WRITE, 1'b1, 1'b0));
    repeat (2) @(posedge core_clk);
    wait_idle();
    check(tx_n, 2 * (PREAMBLE_LEN + 2 + HDR_BYTES));
    check(crc_n, 2);
    check(pop_n, 4);
    check(tx_sig, 64'h0000A1FE5A5A5A5A);
    // interlock: byte counter rewritten in sector one, late in two
    // count and pattern registers stay unread meanwhile
    clr();
    wr(REG_OPCMD, 8'h0C);
    wr(REG_SECT_OP_CNT, 8'h03);
    wr(REG_CMD, cmd(DOP_READ, HOP_IGNORE, 1'b1, 1'b1));
    drv.field(32'h01020304, 1'b1);
    check(rdy_n, 1);
    wr(REG_HDR_BYTE_CNT, 8'h04);
    drv.field(32'h11111111, 1'b1);
    drv.field(32'h01020304, 1'b1);
    check(rdy_n, 2);
    drv.field(32'h22222222, 1'b1);
    check(push_n, 8);
    drv.pulse(1'b0);
    wait_idle();
    rchk(REG_ERROR, 8'h01);
    wr(REG_CMD, cmd(DOP_READ, HOP_IGNORE, 1'b1, 1'b0));
    repeat (3) @(posedge core_clk);
    #1 check(busy, 1'b0);
    wr(REG_OPCMD, 8'h01);
    wr(REG_OPCMD, 8'h00);
    wr(REG_OPCMD, 8'h02);
    rchk(REG_ERROR, 8'h00);
    // accepted again after re-enable; an illegal code ends in error
    wr(REG_CMD, cmd(DOP_NONE, HOP_READ, 1'b1, 1'b0));
    repeat (2) @(posedge core_clk);
    rchk(REG_ERROR, 8'h08);
    // single sector chaining: registers, command, byte counter last
    wr(REG_OPCMD, 8'h01);
    wr(REG_OPCMD, 8'h00);
    wr(REG_OPCMD, 8'h0E);
    clr();
    wr(REG_SUBST, 8'h00);
    wr(REG_CMD, cmd(DOP_READ, HOP_IGNORE, 1'b1, 1'b0));
    wr(REG_HDR_BYTE_CNT, 8'h04);
    #1 check(busy, 1'b1);
    drv.field(32'h01020304, 1'b1);
    check(rdy_n, 1);
    drv.field(32'h0A0B0C0D, 1'b1);
    wait_idle();
    check(push_sig, 64'h0A0B0C0D);
    final_report();
  end
endmodule
